//--- abpm_pkg.sv
// Shared constants for the auxiliary bus pin multiplexer
package abpm_pkg;

  // Pin role codes in the pin function select field
  localparam logic [1:0] ROLE_BUS = 2'h0;
  localparam logic [1:0] ROLE_CS = 2'h1;
  localparam logic [1:0] ROLE_UART = 2'h2;

  // Bit positions in the modem control and status registers
  localparam int MCR_RTS_BIT = 2;
  localparam int MSR_DSR_BIT = 5;

  // Reset levels of the pin and status flip-flops
  localparam logic PIN_IDLE = 1'h1;
  localparam logic OE_OFF = 1'h1;
  localparam logic BIT_CLR = 1'h0;

  // Arbitration states, one-hot
  typedef enum logic [2:0] {
    ARB_IDLE = 3'h1,
    ARB_REQ = 3'h2,
    ARB_OWN = 3'h4
  } abpm_arb_t;

endpackage : abpm_pkg

//--- abpm_bit_reg.sv
// Single reset-valued flip-flop for pin and status outputs
`timescale 1ns/100ps
`default_nettype none
module abpm_bit_reg #(
  parameter logic RST_VAL = 1'h0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Data
  input wire logic d,
  output logic q
);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

endmodule : abpm_bit_reg
`default_nettype wire

//--- abpm_pin_mux.sv
// Role multiplexing for the bus request and bus acknowledge pins
`timescale 1ns/100ps
`default_nettype none
module abpm_pin_mux (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Pin function select
  input wire logic [1:0] req_pin_role,
  input wire logic [1:0] ack_pin_role,
  // Internal bus arbitration
  input wire logic bus_req,
  output logic bus_granted,
  // Chip select decoder
  input wire logic chip_select_six_n,
  input wire logic chip_select_seven_n,
  // UART modem control and status
  input wire logic [7:0] modem_ctrl,
  input wire logic loop_mode,
  output logic msr_dsr,
  output logic dsr_changed,
  // Pins
  output logic aux_bus_request_n,
  input wire logic aux_bus_ack_n_in,
  output logic aux_bus_ack_n_out,
  output logic aux_bus_ack_n_oe_n
);

  abpm_pkg::abpm_arb_t arb_q;
  abpm_pkg::abpm_arb_t arb_d;
  logic req_pin_d;
  logic ack_out_d;
  logic ack_oe_n_d;
  logic dsr_d;
  logic dsr_chg_d;
  logic dsr_chg_q;
  logic bus_mode;

  // Acknowledge only counts while both pins serve the auxiliary bus
  assign bus_mode = (req_pin_role == abpm_pkg::ROLE_BUS) && (ack_pin_role == abpm_pkg::ROLE_BUS);

  always_comb begin
    arb_d = arb_q;
    unique case (arb_q)
      abpm_pkg::ARB_IDLE: begin
        if (bus_mode && bus_req) begin
          arb_d = abpm_pkg::ARB_REQ;
        end
      end
      abpm_pkg::ARB_REQ: begin
        if (!bus_mode || !bus_req) begin
          arb_d = abpm_pkg::ARB_IDLE;
        end else if (!aux_bus_ack_n_in) begin
          arb_d = abpm_pkg::ARB_OWN;
        end
      end
      abpm_pkg::ARB_OWN: begin
        if (!bus_mode || !bus_req) begin
          arb_d = abpm_pkg::ARB_IDLE;
        end
      end
      default: begin
        arb_d = abpm_pkg::ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arb_q <= abpm_pkg::ARB_IDLE;
      dsr_chg_q <= abpm_pkg::BIT_CLR;
    end else begin
      arb_q <= arb_d;
      dsr_chg_q <= dsr_chg_d;
    end
  end

  assign bus_granted = (arb_q == abpm_pkg::ARB_OWN);
  assign dsr_changed = dsr_chg_q;

  // Pin one level
  always_comb begin
    req_pin_d = abpm_pkg::PIN_IDLE;
    unique case (req_pin_role)
      abpm_pkg::ROLE_BUS: req_pin_d = (arb_d == abpm_pkg::ARB_IDLE);
      abpm_pkg::ROLE_CS: req_pin_d = chip_select_six_n;
      abpm_pkg::ROLE_UART: begin
        // Loop mode wins over the control bit
        req_pin_d = loop_mode | ~modem_ctrl[abpm_pkg::MCR_RTS_BIT];
      end
      default: req_pin_d = abpm_pkg::PIN_IDLE;
    endcase
  end

  // Pin two drive and status bit; input roles leave the pin undriven
  always_comb begin
    ack_out_d = abpm_pkg::PIN_IDLE;
    ack_oe_n_d = abpm_pkg::OE_OFF;
    dsr_d = abpm_pkg::BIT_CLR;
    unique case (ack_pin_role)
      abpm_pkg::ROLE_CS: begin
        ack_out_d = chip_select_seven_n;
        ack_oe_n_d = ~abpm_pkg::OE_OFF;
      end
      abpm_pkg::ROLE_UART: dsr_d = ~aux_bus_ack_n_in;
      default: dsr_d = abpm_pkg::BIT_CLR;
    endcase
    dsr_chg_d = (dsr_d != msr_dsr);
  end

  abpm_bit_reg #(.RST_VAL(abpm_pkg::PIN_IDLE)) u_req_pin (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(req_pin_d),
    .q(aux_bus_request_n)
  );

  abpm_bit_reg #(.RST_VAL(abpm_pkg::PIN_IDLE)) u_ack_out (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(ack_out_d),
    .q(aux_bus_ack_n_out)
  );

  abpm_bit_reg #(.RST_VAL(abpm_pkg::OE_OFF)) u_ack_oe (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(ack_oe_n_d),
    .q(aux_bus_ack_n_oe_n)
  );

  abpm_bit_reg #(.RST_VAL(abpm_pkg::BIT_CLR)) u_dsr (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(dsr_d),
    .q(msr_dsr)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_req_wait;
    bus_mode && bus_req && (arb_q == abpm_pkg::ARB_REQ);
  endsequence

  sequence s_ack_seen;
    !aux_bus_ack_n_in;
  endsequence

  property p_grant;
    s_req_wait ##0 s_ack_seen |=> bus_granted ##1 (bus_granted || !$past(bus_mode && bus_req));
  endproperty
  a_grant: assert property (p_grant) else $error("ack did not grant bus");

  property p_req_low;
    (req_pin_role == abpm_pkg::ROLE_BUS) && bus_mode && bus_req |=> !aux_bus_request_n;
  endproperty
  a_req_low: assert property (p_req_low) else $error("bus request not driven low");

  property p_no_grant;
    !bus_mode |=> !bus_granted;
  endproperty
  a_no_grant: assert property (p_no_grant) else $error("grant outside bus role");

  property p_cs6;
    (req_pin_role == abpm_pkg::ROLE_CS) |=> aux_bus_request_n == $past(chip_select_six_n);
  endproperty
  a_cs6: assert property (p_cs6) else $error("pin one not chip select six");

  property p_rts;
    (req_pin_role == abpm_pkg::ROLE_UART) && !loop_mode
      |=> aux_bus_request_n == !$past(modem_ctrl[abpm_pkg::MCR_RTS_BIT]);
  endproperty
  a_rts: assert property (p_rts) else $error("send request not inverse of bit 2");

  property p_rts_loop;
    (req_pin_role == abpm_pkg::ROLE_UART) && loop_mode |=> aux_bus_request_n;
  endproperty
  a_rts_loop: assert property (p_rts_loop) else $error("send request active in loop");

  property p_reset_idle;
    $rose(rstn) |-> aux_bus_request_n && aux_bus_ack_n_oe_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");

  property p_cs7;
    (ack_pin_role == abpm_pkg::ROLE_CS)
      |=> !aux_bus_ack_n_oe_n && (aux_bus_ack_n_out == $past(chip_select_seven_n));
  endproperty
  a_cs7: assert property (p_cs7) else $error("pin two not chip select seven");

  property p_input_role;
    (ack_pin_role != abpm_pkg::ROLE_CS) |=> aux_bus_ack_n_oe_n;
  endproperty
  a_input_role: assert property (p_input_role) else $error("pin two driven in input role");

  property p_dsr;
    (ack_pin_role == abpm_pkg::ROLE_UART) |=> msr_dsr == !$past(aux_bus_ack_n_in)
      && (dsr_changed == ($past(msr_dsr) != msr_dsr));
  endproperty
  a_dsr: assert property (p_dsr) else $error("set-ready bit wrong");

endmodule : abpm_pin_mux
`default_nettype wire

//--- abpm_far_model.sv
// Far-side model: auxiliary processor or modem on pin two
`timescale 1ns/100ps
`default_nettype none
module abpm_far_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Setup
  input wire logic as_modem,
  input wire logic dsr_n,
  input wire logic [1:0] ack_dly,
  // Pins
  input wire logic aux_bus_request_n,
  output logic pin_oe,
  output logic pin_val
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) cnt_q <= 2'h0;
    else if (aux_bus_request_n) cnt_q <= 2'h0;
    else if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
  end
  // Ack low only while the request stands, then released
  assign pin_oe = as_modem | (!aux_bus_request_n && cnt_q > ack_dly);
  assign pin_val = as_modem ? dsr_n : 1'h0;
endmodule : abpm_far_model
`default_nettype wire

//--- abpm_pin_mux_bench.sv
// Self-checking bench for the pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module abpm_pin_mux_bench;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic [1:0] rq_role = 2'h2;
  logic [1:0] ak_role = 2'h0;
  logic bus_req = 1'h0;
  logic cs6_n = 1'h1;
  logic cs7_n = 1'h1;
  logic [7:0] mctl = 8'h04;
  logic loop_mode = 1'h0;
  logic as_modem = 1'h0;
  logic dsr_n = 1'h1;
  logic granted, msr_dsr, dsr_chg, req_n, ak_in, ak_out, ak_oe_n, far_oe, far_val;
  int err_total = 0;
  int num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  // Pull-up holds pin two high when nobody drives it
  assign ak_in = !ak_oe_n ? ak_out : (far_oe ? far_val : 1'h1);
  abpm_pin_mux dut (.clk_sys(clk_sys), .rstn(rstn), .req_pin_role(rq_role),
    .ack_pin_role(ak_role), .bus_req(bus_req), .bus_granted(granted),
    .chip_select_six_n(cs6_n), .chip_select_seven_n(cs7_n), .modem_ctrl(mctl),
    .loop_mode(loop_mode), .msr_dsr(msr_dsr), .dsr_changed(dsr_chg),
    .aux_bus_request_n(req_n), .aux_bus_ack_n_in(ak_in),
    .aux_bus_ack_n_out(ak_out), .aux_bus_ack_n_oe_n(ak_oe_n));
  abpm_far_model far (.clk_sys(clk_sys), .rstn(rstn), .as_modem(as_modem),
    .dsr_n(dsr_n), .ack_dly(2'h2), .aux_bus_request_n(req_n),
    .pin_oe(far_oe), .pin_val(far_val));
  task automatic chk(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %b got %b", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task automatic stop_test;
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // Send request with every control and loop combination
  task automatic t_rts;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      mctl <= i[0] ? 8'h04 : 8'hFB;
      loop_mode <= i[1];
      wt(2);
      chk("rts", i[1] | !i[0], req_n);
    end
  endtask : t_rts
  task automatic t_cs;
    @(posedge clk_sys);
    rq_role <= 2'h1;
    ak_role <= 2'h1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      cs6_n <= i[0];
      cs7_n <= i[1];
      wt(2);
      chk("cs6", i[0], req_n);
      chk("cs7_oe", 1'h0, ak_oe_n);
      chk("cs7", i[1], ak_out);
    end
    // Reserved role code keeps pin one high and pin two undriven
    @(posedge clk_sys);
    rq_role <= 2'h3;
    ak_role <= 2'h3;
    cs6_n <= 1'h0;
    wt(2);
    chk("rsv_pin1", 1'h1, req_n);
    chk("rsv_oe", 1'h1, ak_oe_n);
  endtask : t_cs
  task automatic t_bus;
    @(posedge clk_sys);
    rq_role <= 2'h0;
    ak_role <= 2'h0;
    bus_req <= 1'h1;
    wt(2);
    chk("req", 1'h0, req_n);
    chk("early_grant", 1'h0, granted);
    wt(6);
    chk("grant", 1'h1, granted);
    @(posedge clk_sys);
    bus_req <= 1'h0;
    wt(2);
    chk("req_off", 1'h1, req_n);
  endtask : t_bus
  // Pin two low from the modem must not grant the bus
  task automatic t_dsr;
    @(posedge clk_sys);
    ak_role <= 2'h2;
    as_modem <= 1'h1;
    dsr_n <= 1'h0;
    bus_req <= 1'h1;
    wt(1);
    chk("dsr_chg", 1'h1, dsr_chg);
    wt(3);
    chk("dsr", 1'h1, msr_dsr);
    chk("dsr_chg_end", 1'h0, dsr_chg);
    chk("no_grant", 1'h0, granted);
    chk("no_req", 1'h1, req_n);
    @(posedge clk_sys);
    rq_role <= 2'h2;
    dsr_n <= 1'h1;
    wt(1);
    chk("dsr_chg_off", 1'h1, dsr_chg);
    wt(3);
    chk("dsr_off", 1'h0, msr_dsr);
    chk("rts_loop", 1'h1, req_n);
  endtask : t_dsr
  // Master reset in mid-run while send request is active
  task automatic t_reset;
    @(posedge clk_sys);
    rq_role <= 2'h2;
    loop_mode <= 1'h0;
    mctl <= 8'h04;
    wt(2);
    chk("rts_on", 1'h0, req_n);
    @(posedge clk_sys);
    rstn <= 1'h0;
    wt(2);
    chk("rst_mid", 1'h1, req_n);
    @(posedge clk_sys);
    rstn <= 1'h1;
    wt(0);
    chk("rst_hold", 1'h1, req_n);
    wt(1);
    chk("rts_back", 1'h0, req_n);
  endtask : t_reset
  initial begin
    wt(6);
    chk("rst_rts", 1'h1, req_n);
    repeat (6) @(posedge clk_sys);
    rstn <= 1'h1;
    t_rts();
    t_cs();
    t_bus();
    t_dsr();
    t_reset();
    stop_test();
  end
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule : abpm_pin_mux_bench
`default_nettype wire
